/* File: csb_channel_status_buffer.sv */
// channel-status capture, host and transmit block buffers
//
// Overview of operation
// - hold 384 status bits for two channels, host may read and write
// - status moves input to output only as whole blocks, three buffers
// - each byte msb is earliest bit; first host byte is at 20h
// - capture buffer collects status bits from the receiver as they come
// - host buffer takes whole capture blocks and is host mapped
// - transmit buffer takes whole host blocks, bit source except copy-cycle bit from host image
// - faster output repeats blocks, slower output skips blocks whole
// - flag each capture-to-host and host-to-transmit copy when enabled
// - separate inhibits stop the matching block copy
// - capture copies paced by input blocks, transmit copies by output
// - professional block gets its check byte computed by the device
// - header reserve keeps first five host bytes from capture copies
// - host buffer is 24 words; upper byte channel A, lower channel B
// - a control bit selects one-byte or two-byte host access
// - one-byte read returns channel A or B byte by a control bit
// - one-byte write stores the byte into both channel halves
// - host address auto-increments for consecutive byte transfers
// - two-byte access moves channel A byte first, then channel B
`timescale 1ns/10ps
module csb_channel_status_buffer import csb_pkg::*; (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       clkEn,
   input  wire logic       hostAddrLoad,
   input  wire logic [6:0] hostAddr,
   input  wire logic       hostWrite,
   input  wire logic [7:0] hostWrData,
   input  wire logic       hostRead,
   output logic      [7:0] hostRdData,
   output logic            hostRdValid,
   input  wire logic       inhibitDToE,
   input  wire logic       inhibitEToF,
   input  wire logic       irqEnDToE,
   input  wire logic       irqEnEToF,
   input  wire logic       reserveHeader,
   input  wire logic       twoByteMode,
   input  wire logic       readChanB,
   input  wire logic       rxValid,
   input  wire logic       rxBit,
   input  wire logic       rxSubB,
   input  wire logic       rxBlockStart,
   output logic            rxReady,
   input  wire logic       txReq,
   input  wire logic       txSubB,
   input  wire logic       txBlockStart,
   output logic            txBit,
   output logic            txBitValid,
   output logic            dToEIrq,
   output logic            eToFIrq
);
   // ****************************************************
   // shared decode
   // ****************************************************
   // serial index to bit position, msb first, A in upper byte
   function automatic logic [3:0] bitPos(input logic [7:0] idx,
                                         input logic       chanB);
      bitPos = {~chanB, ~idx[2:0]};
   endfunction

   function automatic logic [4:0] wordOf(input logic [7:0] idx);
      wordOf = idx[7:3];
   endfunction

   // ****************************************************
   // storage
   // ****************************************************
   logic [15:0] capBuf  [CSB_WORDS];
   logic [15:0] hostBuf [CSB_WORDS];
   logic [15:0] txBuf   [CSB_WORDS];

   // ****************************************************
   // receive staging fifo
   // ****************************************************
   wire                      capReady;
   wire                      capValid;
   wire [CSB_FIFO_WIDTH-1:0] capData;

   csb_fifo #(
      .WIDTH (CSB_FIFO_WIDTH),
      .DEPTH (CSB_FIFO_DEPTH)
   ) u_rx_fifo (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .inValid  (rxValid),
      .inData   ({rxBlockStart, rxSubB, rxBit}),
      .inReady  (rxReady),
      .outValid (capValid),
      .outData  (capData),
      .outReady (capReady)
   );

   // ****************************************************
   // capture side
   // ****************************************************
   logic [7:0] capIdx;
   logic       capSynced;
   logic       capFull;

   // drain stalls for the cycle the finished block is handed on
   assign capReady = !capFull;

   wire       capPop   = clkEn && capValid && capReady;
   wire       capStart = capData[2] && !capData[1];
   wire       capIsB   = capData[1];
   wire [7:0] capEff   = capStart ? CSB_IDX_RESET : capIdx;
   wire [4:0] capWord  = wordOf(capEff);
   wire [3:0] capPos   = bitPos(capEff, capIsB);
   wire       capLast  = capIsB && (capEff == CSB_LAST_BIT);
   wire       capOk    = capSynced || capStart;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         capIdx    <= CSB_IDX_RESET;
         capSynced <= 1'b0;
         capFull   <= 1'b0;
      end else if (clkEn) begin
         capFull <= capPop && capOk && capLast;
         if (capPop && capOk) begin
            capSynced <= !capLast;
            if (capLast)
               capIdx <= CSB_IDX_RESET;
            else if (capIsB)
               capIdx <= capEff + 8'h01;
            else
               capIdx <= capEff;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int w = 0; w < CSB_WORDS; w++)
            capBuf[w] <= CSB_WORD_RESET;
      end else if (capPop && capOk) begin
         capBuf[capWord][capPos] <= capData[0];
      end
   end

   // ****************************************************
   // capture to host copy
   // ****************************************************
   // a skipped block is simply dropped when inhibited
   wire dToEFire = clkEn && capFull && !inhibitDToE;

   // ****************************************************
   // host access pointer
   // ****************************************************
   logic [6:0] hostPtr;
   csb_phase_t hostPh;

   wire [6:0] hostOff     = hostPtr - CSB_HOST_BASE;
   wire [4:0] hostWord    = hostOff[4:0];
   wire       hostInRange = (hostPtr >= CSB_HOST_BASE) &&
                            (hostPtr <= CSB_HOST_LAST);
   wire       hostXfer    = clkEn && (hostWrite || hostRead);
   wire       hostAdvance = !twoByteMode || (hostPh == CSB_PH_B);
   wire [15:0] hostCur    = hostInRange ? hostBuf[hostWord]
                                        : CSB_WORD_RESET;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hostPtr <= CSB_HOST_BASE;
         hostPh  <= CSB_PH_A;
      end else if (clkEn) begin
         if (hostAddrLoad) begin
            hostPtr <= hostAddr;
            hostPh  <= CSB_PH_A;
         end else if (hostXfer) begin
            if (hostAdvance)
               hostPtr <= hostPtr + 7'h01;
            case (hostPh)
               CSB_PH_A: hostPh <= twoByteMode ? CSB_PH_B
                                               : CSB_PH_A;
               CSB_PH_B: hostPh <= CSB_PH_A;
               default:  hostPh <= CSB_PH_A;
            endcase
         end
      end
   end

   // ****************************************************
   // host buffer
   // ****************************************************
   wire hostWr = clkEn && hostWrite && !hostAddrLoad && hostInRange;
   wire wrUpper = !twoByteMode || (hostPh == CSB_PH_A);
   wire wrLower = !twoByteMode || (hostPh == CSB_PH_B);

   // host byte written in the copy cycle is kept over the copy
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int w = 0; w < CSB_WORDS; w++)
            hostBuf[w] <= CSB_WORD_RESET;
      end else begin
         if (dToEFire) begin
            for (int w = 0; w < CSB_WORDS; w++)
               if (!(reserveHeader && w < CSB_RSV_WORDS))
                  hostBuf[w] <= capBuf[w];
         end
         if (hostWr && wrUpper)
            hostBuf[hostWord][15:8] <= hostWrData;
         if (hostWr && wrLower)
            hostBuf[hostWord][7:0] <= hostWrData;
      end
   end

   // ****************************************************
   // host read data
   // ****************************************************
   wire rdPickB = twoByteMode ? (hostPh == CSB_PH_B) : readChanB;
   wire [7:0] rdByte = !hostInRange ? CSB_RD_UNMAPPED :
                       rdPickB ? hostCur[7:0] : hostCur[15:8];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hostRdData  <= 8'h00;
         hostRdValid <= 1'b0;
      end else if (clkEn) begin
         hostRdValid <= hostRead && !hostAddrLoad;
         if (hostRead && !hostAddrLoad)
            hostRdData <= rdByte;
      end
   end

   // ****************************************************
   // check byte and transmit image
   // ****************************************************
   wire [CSB_MSG_BITS-1:0] crcMsg [2];
   wire [7:0]              crcOut [2];
   wire [15:0]             txImage [CSB_WORDS];
   wire proA = hostBuf[0][CSB_PRO_BIT_A];
   wire proB = hostBuf[0][CSB_PRO_BIT_B];

   genvar c, g;
   for (c = 0; c < 2; c++) begin : g_crc
      for (g = 0; g < CSB_CRC_WORD; g++) begin : g_msg
         assign crcMsg[c][CSB_MSG_BITS-1-8*g -: 8] =
            hostBuf[g][15-8*c -: 8];
      end
      csb_crc8 u_crc (
         .msg (crcMsg[c]),
         .crc (crcOut[c])
      );
   end

   for (g = 0; g < CSB_WORDS; g++) begin : g_img
      if (g == CSB_CRC_WORD) begin : g_last
         assign txImage[g] = {proA ? crcOut[0] : hostBuf[g][15:8],
                              proB ? crcOut[1] : hostBuf[g][7:0]};
      end else begin : g_body
         assign txImage[g] = hostBuf[g];
      end
   end

   // ****************************************************
   // host to transmit copy and bit output
   // ****************************************************
   logic [7:0] txIdx;

   wire       txFirst  = txReq && txBlockStart && !txSubB;
   wire       eToFFire = clkEn && txFirst && !inhibitEToF;
   wire [7:0] txEff    = txFirst ? CSB_IDX_RESET : txIdx;
   wire [4:0] txWord   = wordOf(txEff);
   wire [3:0] txPos    = bitPos(txEff, txSubB);
   wire [15:0] txSrc   = eToFFire ? txImage[txWord] : txBuf[txWord];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int w = 0; w < CSB_WORDS; w++)
            txBuf[w] <= CSB_WORD_RESET;
      end else if (eToFFire) begin
         for (int w = 0; w < CSB_WORDS; w++)
            txBuf[w] <= txImage[w];
      end
   end

   // an unchanged block is resent when no new copy arrives
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         txIdx      <= CSB_IDX_RESET;
         txBit      <= 1'b0;
         txBitValid <= 1'b0;
      end else if (clkEn) begin
         txBitValid <= txReq;
         if (txReq) begin
            txBit <= txSrc[txPos];
            if (txSubB)
               txIdx <= (txEff == CSB_LAST_BIT) ? CSB_IDX_RESET
                                                : txEff + 8'h01;
            else
               txIdx <= txEff;
         end
      end
   end

   // ****************************************************
   // copy event flags
   // ****************************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dToEIrq <= 1'b0;
         eToFIrq <= 1'b0;
      end else if (clkEn) begin
         dToEIrq <= dToEFire && irqEnDToE;
         eToFIrq <= eToFFire && irqEnEToF;
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_dtoe_irq_on: assert property (
      dToEFire && irqEnDToE |=> dToEIrq ##1 (!dToEIrq || !$past(clkEn) ||
         $past(dToEFire)))
      else $error("capture copy flag missing");
   a_etof_irq_off: assert property (
      clkEn && !(eToFFire && irqEnEToF) |=> !eToFIrq)
      else $error("transmit copy flag without enabled copy");
   a_inhibit_dtoe: assert property (
      clkEn && inhibitDToE && !hostWrite |=>
         $stable(hostBuf[CSB_WORDS-1]))
      else $error("host buffer changed while inhibited");
   a_reserve_hdr: assert property (
      dToEFire && reserveHeader && !hostWrite |=> $stable(hostBuf[0]))
      else $error("reserved header overwritten");
   a_block_copy: assert property (
      dToEFire && !reserveHeader && !hostWrite |=>
         hostBuf[10] == $past(capBuf[10]))
      else $error("capture block not copied whole");
   a_tx_only_start: assert property (
      !$stable(txBuf[3]) |-> $past(eToFFire) && $past(txBlockStart))
      else $error("transmit buffer changed mid block");
   a_tx_crc_byte: assert property (
      eToFFire && proA |=> txBuf[CSB_CRC_WORD][15:8] == $past(crcOut[0]))
      else $error("check byte not inserted");
   a_one_byte_wr: assert property (
      hostWr && !twoByteMode |=>
         hostBuf[$past(hostWord)] == {2{$past(hostWrData)}})
      else $error("one-byte write not mirrored");
   a_rd_chan_b: assert property (
      clkEn && hostRead && !hostAddrLoad && !twoByteMode &&
      readChanB && hostInRange && !dToEFire |=>
         hostRdValid && hostRdData == $past(hostCur[7:0]))
      else $error("channel B byte not returned");
   a_capture_pace: assert property (
      capFull && clkEn |=> !capFull)
      else $error("capture block held over");

   c_dtoe_copy: cover property (dToEFire && reserveHeader);
   c_pro_copy:  cover property (eToFFire && proA && proB);
   c_two_byte:  cover property (hostWr && twoByteMode ##1 hostWr);
   c_rx_stall:  cover property (rxValid && !rxReady);
endmodule // csb_channel_status_buffer

/* File: csb_pkg.sv */
// constants and types shared by the channel-status block buffer
package csb_pkg;
   // ****************************************************
   // block geometry
   // ****************************************************
   localparam int          CSB_WORDS       = 24;
   localparam int          CSB_BITS        = 192;
   localparam logic [7:0]  CSB_LAST_BIT    = 8'hBF;
   localparam int          CSB_RSV_WORDS   = 5;
   localparam int          CSB_CRC_WORD    = 23;
   localparam int          CSB_MSG_BITS    = CSB_CRC_WORD * 8;
   // ****************************************************
   // control port map
   // ****************************************************
   localparam logic [6:0]  CSB_HOST_BASE   = 7'h20;
   localparam logic [6:0]  CSB_HOST_LAST   = 7'h37;
   localparam logic [7:0]  CSB_RD_UNMAPPED = 8'h00;
   // ****************************************************
   // field positions and reset values
   // ****************************************************
   localparam int          CSB_PRO_BIT_A   = 15;
   localparam int          CSB_PRO_BIT_B   = 7;
   localparam logic [15:0] CSB_WORD_RESET  = 16'h0000;
   localparam logic [7:0]  CSB_IDX_RESET   = 8'h00;
   localparam logic [7:0]  CSB_CRC_POLY    = 8'h1D;
   localparam logic [7:0]  CSB_CRC_INIT    = 8'hFF;
   // ****************************************************
   // receive staging buffer
   // ****************************************************
   localparam int          CSB_FIFO_WIDTH  = 3;
   localparam int          CSB_FIFO_DEPTH  = 4;
   // ****************************************************
   // host byte phase
   // ****************************************************
   typedef enum logic {
      CSB_PH_A = 1'b0,
      CSB_PH_B = 1'b1
   } csb_phase_t;
endpackage

/* File: csb_fifo.sv */
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module csb_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             clkEn,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;

   wire full  = (wrPtr[AW] != rdPtr[AW]) &&
                (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
   wire empty = (wrPtr == rdPtr);
   wire push  = clkEn && inValid && !full;
   wire pop   = clkEn && outReady && !empty;

   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = mem[rdPtr[AW-1:0]];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (push) wrPtr <= wrPtr + 1'b1;
         if (pop)  rdPtr <= rdPtr + 1'b1;
      end
   end

   // payload needs no reset, pointers guard it
   always_ff @(posedge ref_clk) begin
      if (push) mem[wrPtr[AW-1:0]] <= inData;
   end
endmodule // csb_fifo

/* File: csb_crc8.sv */
// block check byte over the first 23 bytes of one channel
`timescale 1ns/10ps
module csb_crc8 import csb_pkg::*; (
   input  wire logic [CSB_MSG_BITS-1:0] msg,
   output logic      [7:0]              crc
);
   logic [7:0] acc;
   logic       fb;

   // bits taken in stream order, byte msb first
   always_comb begin
      acc = CSB_CRC_INIT;
      fb  = 1'b0;
      for (int i = CSB_MSG_BITS - 1; i >= 0; i--) begin
         fb  = acc[7] ^ msg[i];
         acc = {acc[6:0], 1'b0} ^ (fb ? CSB_CRC_POLY : 8'h00);
      end
      crc = acc;
   end
endmodule // csb_crc8

/* File: csb_host_model.sv */
// host microcontroller model for the control port
`timescale 1ns/10ps
module csb_host_model (
   input  wire logic       ref_clk,
   output logic            hostAddrLoad,
   output logic      [6:0] hostAddr,
   output logic            hostWrite,
   output logic      [7:0] hostWrData,
   output logic            hostRead,
   input  wire logic [7:0] hostRdData,
   input  wire logic       hostRdValid,
   output logic            inhibitDToE,
   output logic            inhibitEToF
);
   // ***
   // port cycles, one request at a time
   // ***
   initial begin
      {hostAddrLoad, hostWrite, hostRead} = 3'h0;
      {inhibitDToE, inhibitEToF} = 2'h0;
      hostAddr = 7'h00;
      hostWrData = 8'h00;
   end
   // released lines show the inverse, never a stale value
   task automatic load(input logic [6:0] a);
      @(posedge ref_clk);
      hostAddrLoad <= 1'h1;
      hostAddr     <= a;
      @(posedge ref_clk);
      hostAddrLoad <= 1'h0;
      hostAddr     <= ~a;
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge ref_clk);
      hostWrite  <= 1'h1;
      hostWrData <= d;
      @(posedge ref_clk);
      hostWrite  <= 1'h0;
      hostWrData <= ~d;
   endtask
   // answer is registered, so look just after the taking edge
   task automatic rd(output logic [7:0] d, output logic v);
      @(posedge ref_clk);
      hostRead <= 1'h1;
      @(posedge ref_clk);
      hostRead <= 1'h0;
      #1;
      d = hostRdData;
      v = hostRdValid;
   endtask
   // read-modify-write of a channel A byte, two-byte access
   task automatic set_bits(input logic [6:0] a, input logic [7:0] s,
                           output logic [7:0] oldA);
      logic [7:0] b;
      logic       v;
      load(a);
      rd(oldA, v);
      rd(b, v);
      load(a);
      wr(oldA | s);
      wr(b);
   endtask
   // capture copies held off while the host owns the buffer
   task automatic hold_capture(input logic on);
      @(posedge ref_clk);
      inhibitDToE <= on;
   endtask
   task automatic hold_transmit(input logic on);
      @(posedge ref_clk);
      inhibitEToF <= on;
   endtask
endmodule // csb_host_model

/* File: csb_channel_status_buffer_tb.sv */
// self-checking bench for the channel-status block buffer
`timescale 1ns/10ps
module csb_channel_status_buffer_tb import csb_pkg::*; ;
   // ***
   // stimulus, shadow of the host buffer, counters
   // ***
   logic       ref_clk, reset_n, clkEn, irqEnDToE, irqEnEToF, reserveHeader;
   logic       twoByteMode, readChanB, rxValid, rxBit, rxSubB, rxBlockStart;
   logic       txReq, txSubB, txBlockStart;
   logic       hostAddrLoad, hostWrite, hostRead, hostRdValid, rxReady;
   logic       txBit, txBitValid, dToEIrq, eToFIrq, inhibitDToE, inhibitEToF;
   logic [6:0] hostAddr;
   logic [7:0] hostWrData, hostRdData;
   logic [7:0] shA [24] = '{default: 8'h00};
   logic [7:0] shB [24] = '{default: 8'h00};
   logic [7:0] txA [24];
   logic [7:0] txB [24];
   int         errCount = 0, checked = 0, dIrqs = 0, eIrqs = 0;

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      dIrqs <= dIrqs + int'(dToEIrq === 1'h1);
      eIrqs <= eIrqs + int'(eToFIrq === 1'h1);
   end

   csb_channel_status_buffer u_csb_channel_status_buffer (
      .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
      .hostAddrLoad(hostAddrLoad), .hostAddr(hostAddr),
      .hostWrite(hostWrite), .hostWrData(hostWrData), .hostRead(hostRead),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid),
      .inhibitDToE(inhibitDToE), .inhibitEToF(inhibitEToF),
      .irqEnDToE(irqEnDToE), .irqEnEToF(irqEnEToF),
      .reserveHeader(reserveHeader), .twoByteMode(twoByteMode),
      .readChanB(readChanB), .rxValid(rxValid), .rxBit(rxBit),
      .rxSubB(rxSubB), .rxBlockStart(rxBlockStart), .rxReady(rxReady),
      .txReq(txReq), .txSubB(txSubB), .txBlockStart(txBlockStart),
      .txBit(txBit), .txBitValid(txBitValid),
      .dToEIrq(dToEIrq), .eToFIrq(eToFIrq));
   csb_host_model u_csb_host_model (
      .ref_clk(ref_clk), .hostAddrLoad(hostAddrLoad), .hostAddr(hostAddr),
      .hostWrite(hostWrite), .hostWrData(hostWrData), .hostRead(hostRead),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid),
      .inhibitDToE(inhibitDToE), .inhibitEToF(inhibitEToF));

   // ***
   // helpers
   // ***
   function automatic logic [7:0] pat(input int w, input logic [7:0] k);
      return 8'(w) * 8'h25 ^ k;
   endfunction
   function automatic logic [7:0] crc_of(input logic [7:0] m [24]);
      logic [7:0] c;
      c = CSB_CRC_INIT;
      for (int i = 0; i < CSB_CRC_WORD; i++)
         for (int j = 7; j >= 0; j--)
            c = {c[6:0], 1'h0} ^ (c[7] ^ m[i][j] ? CSB_CRC_POLY : 8'h00);
      return c;
   endfunction
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rx_bit(input logic sub, input logic st, input logic b);
      @(posedge ref_clk);
      rxValid      <= 1'h1;
      rxSubB       <= sub;
      rxBlockStart <= st;
      rxBit        <= b;
      @(negedge ref_clk);
      while (rxReady !== 1'h1)
         @(negedge ref_clk);
   endtask
   // first = CSB_WORDS when the copy is expected to be dropped
   task automatic rx_block(input logic [7:0] ka, kb, input int first);
      logic [7:0] a, b;
      for (int f = 0; f < CSB_BITS; f++) begin
         a = pat(f / 8, ka);
         b = pat(f / 8, kb);
         rx_bit(1'h0, f == 0, a[7 - f % 8]);
         rx_bit(1'h1, 1'h0, b[7 - f % 8]);
      end
      @(posedge ref_clk);
      rxValid <= 1'h0;
      rxBit   <= ~rxBit;
      repeat (8) @(posedge ref_clk);
      for (int w = first; w < CSB_WORDS; w++) begin
         shA[w] = pat(w, ka);
         shB[w] = pat(w, kb);
      end
   endtask
   task automatic tx_bit(input logic sub, input logic st, input logic exp);
      @(posedge ref_clk);
      txReq        <= 1'h1;
      txSubB       <= sub;
      txBlockStart <= st;
      @(posedge ref_clk);
      txReq        <= 1'h0;
      #1;
      cmp1(txBitValid, 1'h1);
      cmp1(txBit, exp);
   endtask
   task automatic tx_block;
      for (int f = 0; f < CSB_BITS; f++) begin
         tx_bit(1'h0, f == 0, txA[f / 8][7 - f % 8]);
         tx_bit(1'h1, 1'h0, txB[f / 8][7 - f % 8]);
      end
   endtask
   task automatic prep_tx;
      txA = shA;
      txB = shB;
      if (shA[0][7]) txA[CSB_CRC_WORD] = crc_of(shA);
      if (shB[0][7]) txB[CSB_CRC_WORD] = crc_of(shB);
   endtask
   task automatic read_all;
      logic [7:0] d;
      logic       v;
      u_csb_host_model.load(CSB_HOST_BASE);
      for (int w = 0; w < CSB_WORDS; w++) begin
         u_csb_host_model.rd(d, v);
         cmp8(d, shA[w]);
         u_csb_host_model.rd(d, v);
         cmp8(d, shB[w]);
      end
      cmp1(v, 1'h1);
   endtask

   // ***
   // scenarios
   // ***
   task automatic test_reset;
      logic [7:0] d;
      logic       v;
      read_all;
      u_csb_host_model.load(7'h38);
      u_csb_host_model.wr(8'hA5);
      u_csb_host_model.load(7'h38);
      u_csb_host_model.rd(d, v);
      cmp8(d, CSB_RD_UNMAPPED);
   endtask
   task automatic test_capture;
      int n;
      n = dIrqs;
      @(posedge ref_clk);
      irqEnDToE <= 1'h1;
      rx_block(8'h5A, 8'hC3, 0);
      cmp8(8'(dIrqs - n), 8'h01);
      read_all;
   endtask
   task automatic test_one_byte;
      logic [7:0] d;
      logic       v;
      @(posedge ref_clk);
      twoByteMode <= 1'h0;
      u_csb_host_model.load(CSB_HOST_BASE);
      u_csb_host_model.wr(8'h3C);
      u_csb_host_model.wr(8'h11);
      shA[0] = 8'h3C;
      shB[0] = 8'h3C;
      shA[1] = 8'h11;
      shB[1] = 8'h11;
      for (int c = 0; c < 2; c++) begin
         @(posedge ref_clk);
         readChanB <= c[0];
         u_csb_host_model.load(CSB_HOST_BASE + 7'h01);
         u_csb_host_model.rd(d, v);
         cmp8(d, 8'h11);
         u_csb_host_model.rd(d, v);
         cmp8(d, c ? shB[2] : shA[2]);
      end
   endtask
   task automatic test_reserve;
      @(posedge ref_clk);
      twoByteMode   <= 1'h1;
      reserveHeader <= 1'h1;
      rx_block(8'hA5, 8'h3C, CSB_RSV_WORDS);
      read_all;
   endtask
   task automatic test_inhibit_capture;
      int n;
      u_csb_host_model.hold_capture(1'h1);
      n = dIrqs;
      rx_block(8'h5A, 8'hC3, CSB_WORDS);
      cmp8(8'(dIrqs - n), 8'h00);
      read_all;
   endtask
   task automatic test_transmit;
      logic [7:0] d;
      int         n;
      @(posedge ref_clk);
      irqEnEToF <= 1'h1;
      u_csb_host_model.set_bits(CSB_HOST_BASE, 8'h80, d);
      cmp8(d, shA[0]);
      shA[0] = shA[0] | 8'h80;
      prep_tx;
      n = eIrqs;
      tx_block;
      cmp8(8'(eIrqs - n), 8'h01);
   endtask
   task automatic test_inhibit_transmit;
      int n;
      u_csb_host_model.hold_transmit(1'h1);
      u_csb_host_model.load(CSB_HOST_BASE + 7'h05);
      u_csb_host_model.wr(8'hEE);
      u_csb_host_model.wr(8'h77);
      shA[5] = 8'hEE;
      shB[5] = 8'h77;
      n = eIrqs;
      tx_block;
      cmp8(8'(eIrqs - n), 8'h00);
      u_csb_host_model.hold_transmit(1'h0);
      prep_tx;
      tx_block;
      cmp8(8'(eIrqs - n), 8'h01);
   endtask
   // copy with flag disabled, then a frozen host access must not land
   task automatic test_gates;
      logic [7:0] d;
      logic       v;
      int         n;
      @(posedge ref_clk);
      irqEnDToE     <= 1'h0;
      reserveHeader <= 1'h0;
      u_csb_host_model.hold_capture(1'h0);
      n = dIrqs;
      rx_block(8'h96, 8'h69, 0);
      cmp8(8'(dIrqs - n), 8'h00);
      @(posedge ref_clk);
      clkEn <= 1'h0;
      u_csb_host_model.load(CSB_HOST_BASE);
      u_csb_host_model.wr(8'h00);
      u_csb_host_model.rd(d, v);
      cmp1(v, 1'h0);
      @(posedge ref_clk);
      clkEn <= 1'h1;
      read_all;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // whole run needs well under 10000 cycles
   initial begin
      #2000000;
      errCount++;
      complete_run;
   end
   initial begin
      {ref_clk, reset_n, clkEn, twoByteMode} = 4'h3;
      {irqEnDToE, irqEnEToF, reserveHeader, readChanB} = 4'h0;
      {rxValid, rxBit, rxSubB, rxBlockStart} = 4'h0;
      {txReq, txSubB, txBlockStart} = 3'h0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'h1;
      test_reset;
      test_capture;
      test_one_byte;
      test_reserve;
      test_inhibit_capture;
      test_transmit;
      test_inhibit_transmit;
      test_gates;
      complete_run;
   end
endmodule // csb_channel_status_buffer_tb
